// *** sfsi_pkg.sv ***
// Package for the serial nonvolatile memory slave: opcodes, layouts, timing.
package sfsi_pkg;
  localparam int ADDR_W = 11;
  localparam int DEPTH = 2048;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP0_BIT = 2;
  localparam int SR_BP1_BIT = 3;
  localparam int SR_PEN_BIT = 7;
  localparam logic [7:0] SR_WR_MASK = 8'h8C;
  localparam logic [7:0] SR_RST = 8'h00;
  localparam int SCK_MAX_MHZ = 20;
  localparam int MCLK_MHZ = 100;
  localparam int SCK_MIN_HALF_CYC = MCLK_MHZ / (2 * SCK_MAX_MHZ);

  typedef enum logic [2:0] {
    SFSI_OPC, SFSI_AHI, SFSI_ALO, SFSI_WDATA, SFSI_RDATA, SFSI_SRW,
    SFSI_SRR, SFSI_DEAD
  } sfsi_state_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic hold_n;
  } sfsi_pins_t;
endpackage : sfsi_pkg

// *** sfsi_slave.sv ***
// Serial memory slave: samples the bus pins on mclk and serves a 2K x 8 array.
`timescale 1ns/100ps
// Contract
// R1: The device is active only while chip select is low.
// R2: Chip select high: standby, other inputs ignored, output released.
// R3: Master drops chip select before every opcode.
// R4: Input sampled on rising clock edges, output changes on falling edges.
// R5: Clock may run up to 20 MHz or stop; state stays static.
// R6: Output driven only while returning read data, never during hold.
// R7: Write protect low with protect_enable_bit set blocks status writes.
// R8: Hold low suspends operation and ignores clock and select edges.
// R9: Master changes hold only while the serial clock is low.
// R10: Each byte is committed when its last bit arrives; no busy state.
// R11: Works with master in SPI mode 0 or mode 3.
// R12: Array has 2048 individually addressed bytes.
// R13: Block protect of quarter, half, whole array; write disable command.
// R14: Master may join input and output and must not fight read data.
// R15: First byte after select falls is the opcode, then address, data.
// R16: Two address bytes, MSB first; top five bits ignored.
// R17: Unknown opcode ignored with all input until next select fall.
// R18: All bytes travel most significant bit first.
module sfsi_slave #(
  parameter int DEPTH = sfsi_pkg::DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire sfsi_pkg::sfsi_pins_t pins,
  output logic so_o,
  output logic so_oe_n
);
  sfsi_pkg::sfsi_pins_t s1_ff, s2_ff, s3_ff;
  logic [7:0] mem [DEPTH];
  sfsi_pkg::sfsi_state_t st_ff, nxt_st;
  logic [7:0] sh_ff, nxt_sh;
  logic [2:0] bc_ff, nxt_bc;
  logic [10:0] addr_ff, nxt_addr;
  logic [7:0] sr_ff, nxt_sr;
  logic [7:0] tx_ff, nxt_tx;
  logic so_ff, nxt_so;
  logic oe_n_ff, nxt_oe_n;
  logic rd_ff, nxt_rd;
  logic sr_locked;
  logic wr_en;
  logic [10:0] wr_addr;
  logic [7:0] wr_data;
  logic sel, rise, fall, cs_fall;
  logic [7:0] byte_in;

  // True when the address falls inside the block-protected region.
  function automatic logic prot(input logic [1:0] bp, input logic [10:0] a);
    case (bp)
      2'h1: prot = (a[10:9] == 2'h3);
      2'h2: prot = a[10];
      2'h3: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction : prot

  // Next byte address; wraps from the top of the array back to zero.
  function automatic logic [10:0] addr_next(input logic [10:0] a);
    addr_next = 11'(a + 11'h1);
  endfunction : addr_next

  // States in which the slave owns the output line.
  function automatic logic talks(input sfsi_pkg::sfsi_state_t s);
    talks = (s == sfsi_pkg::SFSI_RDATA) || (s == sfsi_pkg::SFSI_SRR);
  endfunction : talks

  // Two flops per pin, then a third stage for edge finding on clean copies.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Hold freezes the clock view, so edges seen during hold do nothing.
  assign sel = !s2_ff.cs_n && s2_ff.hold_n; // see R1 see R8
  assign rise = sel && s3_ff.hold_n && s2_ff.sck && !s3_ff.sck; // see R4
  assign fall = sel && s3_ff.hold_n && !s2_ff.sck && s3_ff.sck; // see R4
  assign cs_fall = !s2_ff.cs_n && s3_ff.cs_n && s2_ff.hold_n; // see R15
  assign byte_in = {sh_ff[6:0], s2_ff.si}; // see R18
  // Status writes are locked by the pin only while protect_enable_bit is set.
  assign sr_locked = !s2_ff.wp_n && sr_ff[sfsi_pkg::SR_PEN_BIT]; // see R7

  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bc = bc_ff;
    nxt_addr = addr_ff;
    nxt_sr = sr_ff;
    nxt_tx = tx_ff;
    nxt_so = so_ff;
    nxt_oe_n = oe_n_ff;
    nxt_rd = rd_ff;
    wr_en = 1'b0;
    wr_addr = addr_ff;
    wr_data = byte_in;
    // Hold outranks select: a select edge seen while held is ignored.
    if (!s2_ff.hold_n) begin
      nxt_oe_n = 1'b1; // see R6 see R8
    end else if (s2_ff.cs_n) begin
      // Deselect drops the transaction; status and array stay put.
      nxt_st = sfsi_pkg::SFSI_OPC; // see R2 see R3
      nxt_bc = 3'h0;
      nxt_oe_n = 1'b1; // see R2
    end else begin
      if (cs_fall) begin
        nxt_st = sfsi_pkg::SFSI_OPC;
        nxt_bc = 3'h0;
      end
      // A select fall starts a new frame, so it never turns the line on.
      if (sel && talks(st_ff) && !cs_fall) begin
        nxt_oe_n = 1'b0; // see R6 see R14
      end
      if (fall) begin
        nxt_so = tx_ff[7]; // see R4 see R18
        nxt_tx = {tx_ff[6:0], 1'b0};
      end
      if (rise) begin // see R5 see R11
        nxt_sh = byte_in;
        nxt_bc = 3'(bc_ff + 3'h1);
        if (bc_ff == 3'h7) begin
          case (st_ff)
            sfsi_pkg::SFSI_OPC: begin // see R15 see R17
              case (byte_in)
                sfsi_pkg::OP_WREN: begin
                  nxt_sr[sfsi_pkg::SR_WEL_BIT] = 1'b1;
                  nxt_st = sfsi_pkg::SFSI_DEAD;
                end
                sfsi_pkg::OP_WRDI: begin
                  nxt_sr[sfsi_pkg::SR_WEL_BIT] = 1'b0; // see R13
                  nxt_st = sfsi_pkg::SFSI_DEAD;
                end
                sfsi_pkg::OP_RDSR: begin
                  nxt_tx = sr_ff;
                  nxt_st = sfsi_pkg::SFSI_SRR;
                end
                sfsi_pkg::OP_WRSR: nxt_st = sfsi_pkg::SFSI_SRW;
                sfsi_pkg::OP_READ, sfsi_pkg::OP_WRITE: begin
                  nxt_st = sfsi_pkg::SFSI_AHI;
                  // A flag of its own: the output shifter moves on falls.
                  nxt_rd = (byte_in == sfsi_pkg::OP_READ);
                end
                default: nxt_st = sfsi_pkg::SFSI_DEAD; // see R17
              endcase
            end
            sfsi_pkg::SFSI_AHI: begin
              nxt_addr[10:8] = byte_in[2:0]; // see R16
              nxt_st = sfsi_pkg::SFSI_ALO;
            end
            sfsi_pkg::SFSI_ALO: begin
              nxt_addr[7:0] = byte_in; // see R16
              if (rd_ff) begin
                nxt_tx = mem[{addr_ff[10:8], byte_in}];
                nxt_addr = addr_next({addr_ff[10:8], byte_in});
                nxt_st = sfsi_pkg::SFSI_RDATA;
              end else begin
                nxt_st = sfsi_pkg::SFSI_WDATA;
              end
            end
            sfsi_pkg::SFSI_WDATA: begin
              // Commit on the eighth bit; the address wraps in the array.
              wr_en = sr_ff[sfsi_pkg::SR_WEL_BIT] &&
                !prot(sr_ff[sfsi_pkg::SR_BP1_BIT:sfsi_pkg::SR_BP0_BIT],
                      addr_ff); // see R10 see R12 see R13
              nxt_addr = addr_next(addr_ff);
            end
            sfsi_pkg::SFSI_RDATA: begin
              nxt_tx = mem[addr_ff];
              nxt_addr = addr_next(addr_ff);
            end
            sfsi_pkg::SFSI_SRW: begin
              if (sr_ff[sfsi_pkg::SR_WEL_BIT] && !sr_locked) begin
                nxt_sr = (byte_in & sfsi_pkg::SR_WR_MASK) |
                  (sr_ff & ~sfsi_pkg::SR_WR_MASK); // see R7
              end
              nxt_st = sfsi_pkg::SFSI_DEAD;
            end
            sfsi_pkg::SFSI_SRR: nxt_tx = sr_ff;
            default: nxt_st = sfsi_pkg::SFSI_DEAD;
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= sfsi_pkg::SFSI_OPC;
      sh_ff <= 8'h00;
      bc_ff <= 3'h0;
      addr_ff <= 11'h000;
      sr_ff <= sfsi_pkg::SR_RST;
      tx_ff <= 8'h00;
      so_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      rd_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bc_ff <= nxt_bc;
      addr_ff <= nxt_addr;
      sr_ff <= nxt_sr;
      tx_ff <= nxt_tx;
      so_ff <= nxt_so;
      oe_n_ff <= nxt_oe_n;
      rd_ff <= nxt_rd;
    end
  end

  // The array has no reset: it models nonvolatile contents.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data; // see R10
    end
  end

  assign so_o = so_ff;
  assign so_oe_n = oe_n_ff;

  // Checks on the synchronised view; pin timing is the master's concern.
  a_standby_float: assert property ( // see R2
    @(posedge mclk) disable iff (!rst_n)
    s2_ff.cs_n |=> so_oe_n)
    else $error("output driven in standby");
  a_hold_float: assert property ( // see R6
    @(posedge mclk) disable iff (!rst_n)
    !s2_ff.hold_n |=> so_oe_n)
    else $error("output driven in hold");
  a_so_on_fall: assert property ( // see R4
    @(posedge mclk) disable iff (!rst_n)
    !fall |=> $stable(so_o))
    else $error("output moved off edge");
  a_dead_quiet: assert property ( // see R17
    @(posedge mclk) disable iff (!rst_n)
    st_ff == sfsi_pkg::SFSI_DEAD |-> so_oe_n)
    else $error("bad opcode drove output");
  a_wp_locks_sr: assert property ( // see R7
    @(posedge mclk) disable iff (!rst_n)
    (!s2_ff.wp_n && sr_ff[sfsi_pkg::SR_PEN_BIT] && !s2_ff.cs_n) |=>
    $stable(sr_ff & sfsi_pkg::SR_WR_MASK))
    else $error("protected status changed");
  a_write_gate: assert property ( // see R10
    @(posedge mclk) disable iff (!rst_n)
    wr_en |-> rise && sr_ff[sfsi_pkg::SR_WEL_BIT] && bc_ff == 3'h7)
    else $error("write without latch");
  a_hold_freeze: assert property ( // see R8
    @(posedge mclk) disable iff (!rst_n)
    !s2_ff.hold_n |=> $stable(bc_ff))
    else $error("bit count moved in hold");
  a_wrdi_clears: assert property ( // see R13
    @(posedge mclk) disable iff (!rst_n)
    (rise && bc_ff == 3'h7 && st_ff == sfsi_pkg::SFSI_OPC &&
     byte_in == sfsi_pkg::OP_WRDI) |=> !sr_ff[sfsi_pkg::SR_WEL_BIT])
    else $error("write disable ignored");
  a_sel_gates_edge: assert property ( // see R1
    @(posedge mclk) disable iff (!rst_n)
    (rise || fall) |-> !s2_ff.cs_n)
    else $error("clock edge taken while deselected");
  a_talk_only_read: assert property ( // see R6
    @(posedge mclk) disable iff (!rst_n)
    !so_oe_n |-> talks(st_ff))
    else $error("output driven outside read data");
  a_dead_sticky: assert property ( // see R17
    @(posedge mclk) disable iff (!rst_n)
    st_ff == sfsi_pkg::SFSI_DEAD && !s2_ff.cs_n && !s3_ff.cs_n |=>
    st_ff == sfsi_pkg::SFSI_DEAD)
    else $error("ignored frame left its dead state");
  a_cut_frame: assert property ( // see R2
    @(posedge mclk) disable iff (!rst_n)
    s2_ff.cs_n && s2_ff.hold_n |=>
    st_ff == sfsi_pkg::SFSI_OPC && bc_ff == 3'h0)
    else $error("deselect left a frame open");
  a_addr_steps: assert property ( // see R12
    @(posedge mclk) disable iff (!rst_n)
    rise && bc_ff == 3'h7 && st_ff == sfsi_pkg::SFSI_WDATA |=>
    addr_ff == 11'($past(addr_ff) + 11'h1))
    else $error("write address did not step");
  a_prot_blocks: assert property ( // see R13
    @(posedge mclk) disable iff (!rst_n)
    wr_en |-> !prot(sr_ff[sfsi_pkg::SR_BP1_BIT:sfsi_pkg::SR_BP0_BIT],
      wr_addr))
    else $error("write landed in protected block");
  a_hold_keeps_so: assert property ( // see R8
    @(posedge mclk) disable iff (!rst_n)
    !s2_ff.hold_n |=> $stable(so_o) && $stable(st_ff))
    else $error("state moved during hold");
  a_addr_high: assert property ( // see R16
    @(posedge mclk) disable iff (!rst_n)
    rise && bc_ff == 3'h7 && st_ff == sfsi_pkg::SFSI_AHI |=>
    addr_ff[10:8] == $past(byte_in[2:0]))
    else $error("high address bits misplaced");
  a_commit_now: assert property ( // see R10
    @(posedge mclk) disable iff (!rst_n)
    rise && bc_ff == 3'h7 && st_ff == sfsi_pkg::SFSI_WDATA &&
    sr_ff[sfsi_pkg::SR_WEL_BIT] &&
    !prot(sr_ff[sfsi_pkg::SR_BP1_BIT:sfsi_pkg::SR_BP0_BIT], addr_ff) |->
    wr_en)
    else $error("complete byte not committed");
  a_sr_open: assert property ( // see R7
    @(posedge mclk) disable iff (!rst_n)
    rise && bc_ff == 3'h7 && st_ff == sfsi_pkg::SFSI_SRW &&
    sr_ff[sfsi_pkg::SR_WEL_BIT] && s2_ff.wp_n |=>
    sr_ff[sfsi_pkg::SR_PEN_BIT] == $past(byte_in[sfsi_pkg::SR_PEN_BIT]))
    else $error("open status write refused");
  a_wel_kept: assert property ( // see R13
    @(posedge mclk) disable iff (!rst_n)
    st_ff == sfsi_pkg::SFSI_SRW |=> $stable(sr_ff[sfsi_pkg::SR_WEL_BIT]))
    else $error("status write moved the latch");
  a_so_msb: assert property ( // see R18
    @(posedge mclk) disable iff (!rst_n)
    fall |=> so_o == $past(tx_ff[7]))
    else $error("output bit out of order");
endmodule : sfsi_slave

// *** sfsi_master.sv ***
// Bus master model that drives the memory slave's pins in mode 0 or 3.
`timescale 1ns/100ps
module sfsi_master (
  input wire logic so_o,
  input wire logic so_oe_n,
  output sfsi_pkg::sfsi_pins_t p
);
  logic cpol;
  // A released line reads inverted, so stale data never passes as valid.
  wire logic sdo = so_o ^ so_oe_n;
  initial begin
    p = 5'h13;
    cpol = 1'b0;
  end
  task automatic sel(input logic mode3);
    cpol = mode3;
    p.sck = mode3;
    #62.5;
    p.cs_n = 1'b0;
    #62.5;
  endtask : sel
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      p.sck = 1'b0;
      p.si = d[i];
      #62.5;
      q[i] = sdo;
      p.sck = 1'b1;
      #62.5;
    end
  endtask : xb
  // The clock rests between frames, so the slave must keep its state.
  task automatic done;
    p.sck = cpol;
    #62.5;
    p.cs_n = 1'b1;
    #125;
  endtask : done
  task automatic hold(output logic oe);
    p.sck = 1'b0;
    #62.5;
    p.hold_n = 1'b0;
    #62.5;
    oe = so_oe_n;
    repeat (8) begin
      p.sck = 1'b1;
      #62.5;
      p.sck = 1'b0;
      #62.5;
    end
    p.hold_n = 1'b1;
    #62.5;
  endtask : hold
  task automatic wp(input logic v);
    p.wp_n = v;
  endtask : wp
endmodule : sfsi_master

// *** sfsi_slave_tb.sv ***
// Self-checking bench for the serial memory slave.
`timescale 1ns/100ps
module sfsi_slave_tb;
  logic mclk;
  logic rst_n;
  logic so_o;
  logic so_oe_n;
  sfsi_pkg::sfsi_pins_t pins;
  int failures;
  int comparisons;
  sfsi_slave dut (.mclk(mclk), .rst_n(rst_n), .pins(pins), .so_o(so_o),
    .so_oe_n(so_oe_n));
  sfsi_master m (.so_o(so_o), .so_oe_n(so_oe_n), .p(pins));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic cmd(input logic m3, input logic [7:0] op);
    logic [7:0] q;
    m.sel(m3);
    m.xb(op, q);
    m.done;
  endtask : cmd
  task automatic wr(input logic m3, input logic [15:0] a,
    input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] q;
    m.sel(m3);
    m.xb(sfsi_pkg::OP_WRITE, q);
    m.xb(a[15:8], q);
    m.xb(a[7:0], q);
    m.xb(d0, q);
    m.xb(d1, q);
    m.done;
  endtask : wr
  task automatic rd(input logic m3, input logic [15:0] a,
    input logic [7:0] e0, input logic [7:0] e1, input logic h);
    logic [7:0] q;
    logic oe;
    m.sel(m3);
    m.xb(sfsi_pkg::OP_READ, q);
    m.xb(a[15:8], q);
    m.xb(a[7:0], q);
    m.xb(8'h00, q);
    chk8(q, e0);
    if (h) begin
      m.hold(oe);
      chk8({7'h00, oe}, 8'h01);
    end
    m.xb(8'h00, q);
    chk8(q, e1);
    m.done;
  endtask : rd
  task automatic sr(input logic [7:0] v, input logic [7:0] e);
    logic [7:0] q;
    m.sel(1'b0);
    m.xb(sfsi_pkg::OP_WRSR, q);
    m.xb(v, q);
    m.done;
    m.sel(1'b0);
    m.xb(sfsi_pkg::OP_RDSR, q);
    m.xb(8'h00, q);
    chk8(q, e);
    m.done;
  endtask : sr
  task automatic t_disable;
    cmd(1'b0, sfsi_pkg::OP_WREN);
    wr(1'b0, 16'h0005, 8'hA5, 8'h3C);
    cmd(1'b0, sfsi_pkg::OP_WRDI);
    wr(1'b0, 16'h0005, 8'h5A, 8'hC3);
    rd(1'b0, 16'h0005, 8'hA5, 8'h3C, 1'b0);
  endtask : t_disable
  task automatic t_wrap;
    cmd(1'b1, sfsi_pkg::OP_WREN);
    wr(1'b1, 16'hFFFF, 8'h81, 8'h42);
    rd(1'b0, 16'hF7FF, 8'h81, 8'h42, 1'b1);
    rd(1'b1, 16'h07FF, 8'h81, 8'h42, 1'b0);
  endtask : t_wrap
  task automatic t_status;
    sr(8'h8C, 8'h8E);
    wr(1'b0, 16'h07FF, 8'h11, 8'h22);
    rd(1'b0, 16'h07FF, 8'h81, 8'h42, 1'b0);
    m.wp(1'b0);
    sr(8'h00, 8'h8E);
    m.wp(1'b1);
    sr(8'h84, 8'h86);
    wr(1'b0, 16'h07FF, 8'h99, 8'h88);
    rd(1'b0, 16'h07FF, 8'h81, 8'h88, 1'b0);
    sr(8'h08, 8'h0A);
    wr(1'b0, 16'h07FF, 8'h12, 8'h34);
    rd(1'b0, 16'h07FF, 8'h81, 8'h34, 1'b0);
  endtask : t_status
  task automatic t_badop;
    logic [7:0] q;
    m.sel(1'b0);
    m.xb(8'hFF, q);
    m.xb(sfsi_pkg::OP_READ, q);
    m.xb(8'h07, q);
    chk8({7'h00, so_oe_n}, 8'h01);
    m.xb(8'hFF, q);
    m.xb(8'h00, q);
    chk8({7'h00, so_oe_n}, 8'h01);
    m.done;
    chk8({7'h00, so_oe_n}, 8'h01);
    rd(1'b0, 16'h07FF, 8'h81, 8'h34, 1'b0);
  endtask : t_badop
  task automatic conclude;
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    failures = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    // Offset the serial clock so none of its edges meets an mclk edge.
    #1;
    chk8({7'h00, so_oe_n}, 8'h01);
    t_disable;
    t_wrap;
    t_status;
    t_badop;
    conclude;
  end
endmodule : sfsi_slave_tb
